// *** hdl/psd_core.sv ***
// Synthesizer digital core: serial port, dividers, lock detect, band select
//
// Summary of operation
// - Feedback divides VCO by prescaler times main plus swallow
// - Prescaler selectable as 8/9, 16/17 or 32/33
// - Main counter 13 bits, divide 3 to 8191
// - Swallow count 0 to 31 selects larger modulus
// - Reference divider 14 bits, ratio 1 to 16383
// - Two-bit field sets anti-backlash pulse width
// - Three-bit field selects test-point output signal
// - Loose precision: three good cycles assert lock
// - Tight precision: five good cycles assert lock
// - Lock holds until error above unlock window
// - 24-bit shift register, MSB first, serial clock rise
// - Load strobe rise copies word into selected latch
// - Codes 00 control, 01 ref, 10 feedback, 11 test
// - Band select runs at power-up and feedback write
// - Band select lasts five cycles, tuning node parked
// - Band select clock is reference output divided by 1, 2, 4 or 8
// - Two-bit core power field sets VCO core current
// - Two-bit output power field sets tail current
// - Mute-until-lock keeps output stage off until lock
`timescale 1ns/1ps
module psd_core
   import psd_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Three-wire port and analog-side clocks, all asynchronous
   input wire logic serial_clk_in,
   input wire logic serial_data_in,
   input wire logic latch_load_strobe_in,
   input wire logic ref_clk_in,
   input wire logic vco_clk_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Analog controls
   output logic [1:0] core_power_out,
   output logic [1:0] output_power_out,
   output logic [1:0] antibacklash_width_out,
   output logic half_rate_output_select_out,
   output logic rf_output_enable_out,
   output logic vtune_ref_connect_out,
   output logic lock_detect_out,
   output logic testpoint_output_out
);

   logic [2:0] sclk_sync_reg;
   logic [1:0] sdat_sync_reg;
   logic [2:0] le_sync_reg;
   logic [2:0] ref_sync_reg;
   logic [2:0] vco_sync_reg;
   logic sclk_rise;
   logic le_rise;
   logic ref_tick;
   logic vco_tick;

   // Bit 0 of each chain is the first stage and is read only by bit 1
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sclk_sync_reg <= 3'h0;
         sdat_sync_reg <= 2'h0;
         le_sync_reg <= 3'h0;
         ref_sync_reg <= 3'h0;
         vco_sync_reg <= 3'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clk_in};
         sdat_sync_reg <= {sdat_sync_reg[0], serial_data_in};
         le_sync_reg <= {le_sync_reg[1:0], latch_load_strobe_in};
         ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_in};
         vco_sync_reg <= {vco_sync_reg[1:0], vco_clk_in};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
   assign le_rise = le_sync_reg[1] && !le_sync_reg[2];
   assign ref_tick = ref_sync_reg[1] && !ref_sync_reg[2];
   assign vco_tick = vco_sync_reg[1] && !vco_sync_reg[2];

   // Serial shift register
   logic [WORD_W-1:0] shift_reg;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift_reg <= '0;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[WORD_W-2:0], sdat_sync_reg[1]};
      end
   end

   // AHB-Lite slave, zero wait states
   logic dph_wr_reg;
   logic [7:0] dph_addr_reg;
   logic addr_take;
   logic bus_load;
   logic [31:0] rd_next;
   logic [23:0] ctrl_latch_reg;
   logic [23:0] ref_latch_reg;
   logic [23:0] fb_latch_reg;
   logic [23:0] test_latch_reg;
   logic lock_reg;
   psd_bsel_e bs_state_reg;

   assign addr_take = hsel_in && hready_in && htrans_in[1];
   assign bus_load = dph_wr_reg && (dph_addr_reg == OFS_LATCH_WRITE);
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   always_comb begin
      rd_next = 32'h00000000;
      case (haddr_in[7:0])
         OFS_CONTROL: rd_next = {8'h00, ctrl_latch_reg};
         OFS_REFDIV: rd_next = {8'h00, ref_latch_reg};
         OFS_FEEDBACK: rd_next = {8'h00, fb_latch_reg};
         OFS_TEST: rd_next = {8'h00, test_latch_reg};
         OFS_STATUS: rd_next = {29'h00000000, rf_output_enable_out,
                                bs_state_reg == BS_RUN, lock_reg};
         default: rd_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dph_wr_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
         hrdata_out <= 32'h00000000;
      end else begin
         // Writes outside the low page are dropped, not aliased onto the latch port
         dph_wr_reg <= addr_take && hwrite_in && haddr_in[31:8] == 24'h000000;
         if (addr_take) begin
            dph_addr_reg <= haddr_in[7:0];
         end
         if (addr_take && !hwrite_in && haddr_in[31:8] == 24'h000000) begin
            hrdata_out <= rd_next;
         end else begin
            hrdata_out <= 32'h00000000;
         end
      end
   end

   // Latch load: serial strobe wins over a bus write in the same cycle
   logic load_evt;
   logic [23:0] load_word;

   assign load_evt = le_rise || bus_load;
   assign load_word = le_rise ? shift_reg : hwdata_in[23:0];
   logic ld_ctrl;
   logic ld_ref;
   logic ld_fb;
   logic ld_test;
   assign ld_ctrl = load_evt && load_word[1:0] == SEL_CONTROL;
   assign ld_ref = load_evt && load_word[1:0] == SEL_REFDIV;
   assign ld_fb = load_evt && load_word[1:0] == SEL_FEEDBACK;
   assign ld_test = load_evt && load_word[1:0] == SEL_TEST;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_latch_reg <= CONTROL_RST;
         ref_latch_reg <= REFDIV_RST;
         fb_latch_reg <= FEEDBACK_RST;
         test_latch_reg <= TEST_RST;
      end else begin
         if (ld_ctrl) ctrl_latch_reg <= load_word;
         if (ld_ref) ref_latch_reg <= load_word;
         if (ld_fb) fb_latch_reg <= load_word;
         if (ld_test) test_latch_reg <= load_word;
      end
   end

   // Field decode
   logic [12:0] main_div;
   logic [4:0] swallow_div;
   logic [13:0] ref_div;
   logic [5:0] psc_mod;
   logic [1:0] psc_code;
   logic [12:0] main_raw;
   logic [13:0] ref_raw;

   assign psc_code = ctrl_latch_reg[CL_PSC_LSB +: 2];
   assign main_raw = fb_latch_reg[NL_B_LSB +: 13];
   assign ref_raw = ref_latch_reg[RL_R_LSB +: 14];
   assign main_div = (main_raw < MAIN_MIN) ? MAIN_MIN : main_raw;
   assign swallow_div = fb_latch_reg[NL_A_LSB +: 5];
   assign ref_div = (ref_raw < REF_MIN) ? REF_MIN : ref_raw;
   always_comb begin
      case (psc_code)
         PSC_8: psc_mod = 6'd8;
         PSC_16: psc_mod = 6'd16;
         default: psc_mod = 6'd32;
      endcase
   end

   // Feedback divider; a control or feedback load restarts it
   logic [5:0] psc_cnt_reg;
   logic [4:0] swl_left_reg;
   logic [12:0] main_cnt_reg;
   logic [5:0] psc_cur;
   logic psc_wrap;
   logic n_tick;
   logic fb_restart;

   assign fb_restart = ld_ctrl || ld_fb;
   assign psc_cur = (swl_left_reg != 5'h00) ? psc_mod + 6'd1 : psc_mod;
   assign psc_wrap = vco_tick && psc_cnt_reg == psc_cur - 6'd1;
   assign n_tick = psc_wrap && main_cnt_reg == main_div - 13'd1;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         psc_cnt_reg <= 6'h00;
         swl_left_reg <= 5'h00;
         main_cnt_reg <= 13'h0000;
      end else if (fb_restart) begin
         psc_cnt_reg <= 6'h00;
         swl_left_reg <= ld_fb ? load_word[NL_A_LSB +: 5] : swallow_div;
         main_cnt_reg <= 13'h0000;
      end else if (vco_tick) begin
         if (psc_wrap) begin
            psc_cnt_reg <= 6'h00;
            if (n_tick) begin
               main_cnt_reg <= 13'h0000;
               swl_left_reg <= swallow_div;
            end else begin
               main_cnt_reg <= main_cnt_reg + 13'd1;
               if (swl_left_reg != 5'h00) swl_left_reg <= swl_left_reg - 5'd1;
            end
         end else begin
            psc_cnt_reg <= psc_cnt_reg + 6'd1;
         end
      end
   end

   // Reference divider and band select clock divider
   logic [13:0] r_cnt_reg;
   logic [2:0] bsc_cnt_reg;
   logic [2:0] bsc_mask;
   logic r_tick;
   logic bs_tick;

   assign r_tick = ref_tick && r_cnt_reg == ref_div - 14'd1;
   assign bsc_mask = 3'((4'h1 << ref_latch_reg[RL_BSC_LSB +: 2]) - 4'h1);
   assign bs_tick = r_tick && bsc_cnt_reg == bsc_mask;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r_cnt_reg <= 14'h0000;
         bsc_cnt_reg <= 3'h0;
      end else if (ld_ref) begin
         r_cnt_reg <= 14'h0000;
         bsc_cnt_reg <= 3'h0;
      end else begin
         if (r_tick) r_cnt_reg <= 14'h0000;
         else if (ref_tick) r_cnt_reg <= r_cnt_reg + 14'd1;
         if (bs_tick) bsc_cnt_reg <= 3'h0;
         else if (r_tick) bsc_cnt_reg <= bsc_cnt_reg + 3'd1;
      end
   end

   // Phase error: cycles between reference and feedback edges
   logic pend_r_reg;
   logic pend_n_reg;
   logic [3:0] err_cnt_reg;
   logic pd_done;
   logic [3:0] pd_err;

   always_comb begin
      pd_done = 1'b0;
      pd_err = 4'h0;
      if (r_tick && n_tick) begin
         pd_done = 1'b1;
      end else if ((pend_r_reg && n_tick) || (pend_n_reg && r_tick)) begin
         pd_done = 1'b1;
         pd_err = (err_cnt_reg == 4'hF) ? 4'hF : err_cnt_reg + 4'd1;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_r_reg <= 1'b0;
         pend_n_reg <= 1'b0;
         err_cnt_reg <= 4'h0;
      end else if (pd_done || fb_restart || ld_ref) begin
         pend_r_reg <= 1'b0;
         pend_n_reg <= 1'b0;
         err_cnt_reg <= 4'h0;
      end else begin
         if (r_tick) pend_r_reg <= 1'b1;
         if (n_tick) pend_n_reg <= 1'b1;
         if ((pend_r_reg || pend_n_reg) && err_cnt_reg != 4'hF) begin
            err_cnt_reg <= err_cnt_reg + 4'd1;
         end
      end
   end

   // Digital lock detect
   logic [2:0] qual_reg;
   logic [2:0] qual_need;
   logic good_cycle;
   logic bad_cycle;

   assign qual_need = ref_latch_reg[RL_LDP_BIT] ? LOCK_QUAL_TIGHT : LOCK_QUAL_LOOSE;
   assign good_cycle = pd_done && pd_err <= LOCK_ERR_CYC;
   assign bad_cycle = pd_done && pd_err > UNLOCK_ERR_CYC;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         qual_reg <= 3'h0;
         lock_reg <= 1'b0;
      end else if (bad_cycle) begin
         qual_reg <= 3'h0;
         lock_reg <= 1'b0;
      end else if (good_cycle && !lock_reg) begin
         if (qual_reg + 3'd1 >= qual_need) begin
            lock_reg <= 1'b1;
            qual_reg <= 3'h0;
         end else begin
            qual_reg <= qual_reg + 3'd1;
         end
      end else if (pd_done && !lock_reg) begin
         qual_reg <= 3'h0;
      end
   end

   // Band select; reset value gives the power-up run
   logic [2:0] bs_left_reg;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bs_state_reg <= BS_RUN;
         bs_left_reg <= BSEL_CYCLES;
      end else if (ld_fb) begin
         bs_state_reg <= BS_RUN;
         bs_left_reg <= BSEL_CYCLES;
      end else begin
         case (bs_state_reg)
            BS_IDLE: bs_left_reg <= 3'h0;
            BS_RUN: begin
               if (bs_tick) begin
                  bs_left_reg <= bs_left_reg - 3'd1;
                  if (bs_left_reg == 3'h1) bs_state_reg <= BS_IDLE;
               end
            end
            default: begin
               bs_state_reg <= BS_IDLE;
               bs_left_reg <= 3'h0;
            end
         endcase
      end
   end

   // Outputs, all from flops
   logic ndiv_tog_reg;
   logic rdiv_tog_reg;
   logic tp_next;

   always_comb begin
      case (ctrl_latch_reg[CL_TP_LSB +: 3])
         TP_LOCK: tp_next = lock_reg;
         TP_NDIV: tp_next = ndiv_tog_reg;
         TP_HIGH: tp_next = 1'b1;
         TP_RDIV: tp_next = rdiv_tog_reg;
         TP_BSEL: tp_next = bs_state_reg == BS_RUN;
         default: tp_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ndiv_tog_reg <= 1'b0;
         rdiv_tog_reg <= 1'b0;
         testpoint_output_out <= 1'b0;
         core_power_out <= 2'h0;
         output_power_out <= 2'h0;
         antibacklash_width_out <= 2'h0;
         half_rate_output_select_out <= 1'b0;
         rf_output_enable_out <= 1'b0;
         vtune_ref_connect_out <= 1'b0;
         lock_detect_out <= 1'b0;
      end else begin
         if (n_tick) ndiv_tog_reg <= !ndiv_tog_reg;
         if (r_tick) rdiv_tog_reg <= !rdiv_tog_reg;
         testpoint_output_out <= tp_next;
         core_power_out <= ctrl_latch_reg[CL_CPWR_LSB +: 2];
         output_power_out <= ctrl_latch_reg[CL_OPWR_LSB +: 2];
         antibacklash_width_out <= ref_latch_reg[RL_ABP_LSB +: 2];
         half_rate_output_select_out <= fb_latch_reg[NL_HALF_RATE_OUTPUT_SELECT_BIT];
         // Output stage held off while muted and not locked
         rf_output_enable_out <= !ctrl_latch_reg[CL_MUTE_BIT] || lock_reg;
         vtune_ref_connect_out <= bs_state_reg == BS_RUN;
         lock_detect_out <= lock_reg;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   logic [18:0] vco_since_reg;
   logic [18:0] n_expect;
   assign n_expect = 19'(psc_mod) * 19'(main_div) + 19'(swallow_div);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) vco_since_reg <= 19'h00000;
      else if (fb_restart || n_tick) vco_since_reg <= 19'h00000;
      else if (vco_tick) vco_since_reg <= vco_since_reg + 19'd1;
   end

   n_period_a: assert property (n_tick |-> vco_since_reg + 19'd1 == n_expect)
      else $error("feedback period wrong");
   main_min_a: assert property (main_div >= MAIN_MIN && ref_div != 14'h0000)
      else $error("divider below minimum");
   shift_in_a: assert property (sclk_rise |=> shift_reg[0] == $past(sdat_sync_reg[1]))
      else $error("serial bit not shifted");
   latch_ctrl_a: assert property (le_rise && shift_reg[1:0] == SEL_CONTROL
      |=> ctrl_latch_reg == $past(shift_reg))
      else $error("control latch not loaded");
   latch_fb_a: assert property (le_rise && shift_reg[1:0] == SEL_FEEDBACK
      |=> fb_latch_reg == $past(shift_reg) && ctrl_latch_reg == $past(ctrl_latch_reg))
      else $error("feedback latch select wrong");
   latch_hold_a: assert property (!load_evt |=> $stable(ctrl_latch_reg)
      && $stable(ref_latch_reg) && $stable(fb_latch_reg))
      else $error("latch changed without load");
   lock_rise_a: assert property ($rose(lock_reg) |-> $past(good_cycle)
      && $past(qual_reg) + 3'd1 >= $past(qual_need))
      else $error("lock asserted early");
   unlock_a: assert property (bad_cycle |=> !lock_reg ##1 !lock_detect_out)
      else $error("lock kept after bad cycle");
   bsel_start_a: assert property (ld_fb |=> bs_state_reg == BS_RUN
      ##1 vtune_ref_connect_out)
      else $error("band select not started");
   mute_a: assert property (ctrl_latch_reg[CL_MUTE_BIT] && !lock_reg
      |=> !rf_output_enable_out)
      else $error("output not muted");

   lock_cov_c: cover property ($rose(lock_detect_out));
   bsel_done_c: cover property ($fell(vtune_ref_connect_out));
   serial_load_c: cover property (le_rise ##[1:100] n_tick);
   bus_load_c: cover property (bus_load);
endmodule

// *** include/psd_pkg.sv ***
// Constants for the synthesizer digital core
package psd_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 50;
   // Lock detect phase windows
   localparam int LOCK_ERR_NS = 15;
   localparam int UNLOCK_ERR_NS = 25;
   localparam logic [3:0] LOCK_ERR_CYC = 4'(LOCK_ERR_NS / CLK_PERIOD_NS);
   localparam logic [3:0] UNLOCK_ERR_CYC = 4'(UNLOCK_ERR_NS / CLK_PERIOD_NS);
   localparam logic [2:0] LOCK_QUAL_LOOSE = 3'h3;
   localparam logic [2:0] LOCK_QUAL_TIGHT = 3'h5;
   // Band select length in band select clock cycles
   localparam logic [2:0] BSEL_CYCLES = 3'h5;
   // Serial word and latch select codes
   localparam int WORD_W = 24;
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_REFDIV = 2'h1;
   localparam logic [1:0] SEL_FEEDBACK = 2'h2;
   localparam logic [1:0] SEL_TEST = 2'h3;
   // Control latch fields
   localparam int CL_PSC_LSB = 22;
   localparam int CL_OPWR_LSB = 12;
   localparam int CL_MUTE_BIT = 11;
   localparam int CL_TP_LSB = 5;
   localparam int CL_CPWR_LSB = 2;
   // Reference divider latch fields
   localparam int RL_BSC_LSB = 20;
   localparam int RL_LDP_BIT = 18;
   localparam int RL_ABP_LSB = 16;
   localparam int RL_R_LSB = 2;
   // Feedback latch fields
   localparam int NL_HALF_RATE_OUTPUT_SELECT_BIT = 23;
   localparam int NL_B_LSB = 8;
   localparam int NL_A_LSB = 2;
   localparam logic [12:0] MAIN_MIN = 13'h0003;
   localparam logic [13:0] REF_MIN = 14'h0001;
   // Prescaler codes
   localparam logic [1:0] PSC_8 = 2'h0;
   localparam logic [1:0] PSC_16 = 2'h1;
   // Latch reset values
   localparam logic [23:0] CONTROL_RST = 24'h000000;
   localparam logic [23:0] REFDIV_RST = 24'h000001;
   localparam logic [23:0] FEEDBACK_RST = 24'h000002;
   localparam logic [23:0] TEST_RST = 24'h000003;
   // Bus register byte offsets
   localparam logic [7:0] OFS_LATCH_WRITE = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_REFDIV = 8'h08;
   localparam logic [7:0] OFS_FEEDBACK = 8'h0C;
   localparam logic [7:0] OFS_TEST = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // Test-point selections
   localparam logic [2:0] TP_LOW = 3'h0;
   localparam logic [2:0] TP_LOCK = 3'h1;
   localparam logic [2:0] TP_NDIV = 3'h2;
   localparam logic [2:0] TP_HIGH = 3'h3;
   localparam logic [2:0] TP_RDIV = 3'h4;
   localparam logic [2:0] TP_BSEL = 3'h5;
   typedef enum logic [1:0] {
      BS_IDLE = 2'b01,
      BS_RUN = 2'b10
   } psd_bsel_e;
endpackage

// *** testbench/psd_host.sv ***
// Host model driving the three-wire programming port
`timescale 1ns/1ps
module psd_host (
   input wire logic clk_in,
   output logic sclk_out,
   output logic sdata_out,
   output logic strobe_out
);
   initial begin
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      strobe_out = 1'b0;
   end
   // Every phase spans 3 clocks so the 2-flop sync cannot miss it
   task automatic send(input logic [23:0] word, input logic load);
      for (int i = 23; i >= 0; i--) begin
         sdata_out <= word[i];
         repeat (3) @(posedge clk_in);
         sclk_out <= 1'b1;
         repeat (3) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      // Data no longer valid, so show the opposite level
      sdata_out <= ~word[0];
      repeat (3) @(posedge clk_in);
      strobe_out <= load;
      repeat (3) @(posedge clk_in);
      strobe_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// *** testbench/tb_top.sv ***
// Testbench for the synthesizer digital core
`timescale 1ns/1ps
module tb_top import psd_pkg::*;;
   logic clk_in, arst_n_in, hwrite, hreadyout, ref_clk, vco_clk, tick_en, drop, drop_req;
   logic hresp;
   logic sclk, sdata, strobe, half_rate, rf_en, vtune, lock, tp;
   logic [1:0] htrans, core_pwr, out_pwr, abw;
   logic [2:0] cnt;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int n_errors, checks;

   psd_host host_u (.clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));

   psd_core dut_u (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .serial_clk_in(sclk), .serial_data_in(sdata),
      .latch_load_strobe_in(strobe), .ref_clk_in(ref_clk), .vco_clk_in(vco_clk),
      .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(hresp), .core_power_out(core_pwr),
      .output_power_out(out_pwr), .antibacklash_width_out(abw),
      .half_rate_output_select_out(half_rate), .rf_output_enable_out(rf_en),
      .vtune_ref_connect_out(vtune), .lock_detect_out(lock), .testpoint_output_out(tp)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Same tick feeds both dividers, so equal counts line up exactly
   always @(posedge clk_in) begin
      if (!tick_en) begin
         cnt <= 3'h0;
         ref_clk <= 1'b0;
         vco_clk <= 1'b0;
      end else begin
         cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
         ref_clk <= (cnt < 3'h3);
         vco_clk <= (cnt < 3'h3) && !drop;
         if (cnt == 3'h5) drop <= drop_req;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
      chk(32'(hresp), 32'h0);
   endtask

   task automatic run_lock(input logic [1:0] k);
      int p;
      int t;
      p = (k == 2'h0) ? 8 : (k == 2'h1) ? 16 : 32;
      t = (3 * p + 2) * 6;
      tick_en <= 1'b0;
      repeat (4) @(posedge clk_in);
      bus(1'b1, 32'h0, (32'(k[0]) << 18) | (32'(3 * p + 2) << 2) | 32'h1);
      bus(1'b1, 32'h0, (32'(k) << 22) | (32'(k[1]) << 11) | 32'h20);
      bus(1'b1, 32'h0, 32'h0000030A);
      repeat (4) @(posedge clk_in);
      tick_en <= 1'b1;
      repeat (t * 7 / 2) @(posedge clk_in);
      chk(32'(lock), 32'(!k[0]));
      chk(32'(rf_en), 32'(!(k[0] && k[1])));
      chk(32'(tp), 32'(!k[0]));
      repeat (t) @(posedge clk_in);
      chk(32'(vtune), 32'h1);
      repeat (t) @(posedge clk_in);
      chk(32'(vtune), 32'h0);
      chk(32'(lock), 32'h1);
      rdchk(32'(OFS_STATUS), 32'h5);
      // Drop one tick so the feedback edge slips a whole tick behind
      drop_req <= 1'b1;
      repeat (6) @(posedge clk_in);
      drop_req <= 1'b0;
      repeat (t * 3 / 2) @(posedge clk_in);
      chk(32'(lock), 32'h0);
      chk(32'(rf_en), 32'(!k[1]));
   endtask

   initial begin
      repeat (60000) @(posedge clk_in);
      n_errors++;
      end_of_test();
   end

   initial begin
      arst_n_in = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      tick_en = 1'b0;
      drop = 1'b0;
      drop_req = 1'b0;
      n_errors = 0;
      checks = 0;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      for (int k = 0; k < 4; k++) begin
         rdchk(32'(OFS_CONTROL) + 32'(4 * k), 32'(k));
      end
      chk(32'(vtune), 32'h1);
      for (int k = 0; k < 4; k++) begin
         host_u.send({20'h9C3A5, 2'(k), 2'(k)}, 1'b1);
         rdchk(32'(OFS_CONTROL) + 32'(4 * k), {8'h0, 20'h9C3A5, 2'(k), 2'(k)});
      end
      host_u.send(24'h5A5A5B, 1'b0);
      rdchk(32'(OFS_TEST), 32'h009C3A5F);
      bus(1'b1, 32'h20, 32'hFFFFFFFF);
      rdchk(32'h20, 32'h0);
      bus(1'b1, 32'(OFS_CONTROL), 32'h0);
      rdchk(32'(OFS_CONTROL), 32'h009C3A50);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, 32'h0, 32'(k << 2) | 32'((3 - k) << 12) | 32'((k % 2) * 3 << 5));
         bus(1'b1, 32'h0, 32'(k << 16) | 32'h1);
         bus(1'b1, 32'h0, 32'((k % 2) << 23) | 32'h0000030A);
         repeat (2) @(posedge clk_in);
         chk(32'(core_pwr), 32'(k));
         chk(32'(out_pwr), 32'(3 - k));
         chk(32'(tp), 32'(k % 2));
         chk(32'(abw), 32'(k));
         chk(32'(half_rate), 32'(k % 2));
      end
      // Band select still pending from the last feedback write, no ticks yet
      bus(1'b1, 32'h0, 32'h000000A0);
      repeat (2) @(posedge clk_in);
      chk(32'(tp), 32'h1);
      bus(1'b1, 32'h100, 32'h000000E0);
      rdchk(32'(OFS_CONTROL), 32'h000000A0);
      for (int k = 0; k < 4; k++) begin
         run_lock(2'(k));
      end
      end_of_test();
   end
endmodule
